// >>> rtl/spa_pkg.sv
package spa_pkg;
	localparam int ADDR_W = 16;
	localparam logic [15:0] OFS_CTRL0 = 16'h1983;
	localparam logic [15:0] OFS_MASK = 16'h1997;
	localparam logic [15:0] OFS_RDI2 = 16'h19c9;
	localparam logic [15:0] OFS_RDI1 = 16'h19ca;
	localparam logic [15:0] OFS_RDI0 = 16'h19cb;
	localparam logic [15:0] OFS_SW_RDI = 16'h19cc;
	localparam logic [15:0] OFS_STATUS = 16'h19cd;
	localparam logic [7:0] RST_CTRL0 = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_RDI = 8'h00;
	localparam logic [7:0] CTRL0_WMASK = 8'hfd;
	localparam int CTRL_AIS_BIT = 0;
	localparam int CTRL_RDI_SEL_LO = 3;
	localparam int EN_LO_BIT = 0;
	localparam int EN_HI_BIT = 4;
	localparam int CODE_LO_POS = 1;
	localparam int CODE_HI_POS = 5;
	localparam logic [1:0] RDI_SEL_AUTO = 2'h0;
	localparam logic [1:0] RDI_SEL_SW = 2'h1;
	localparam logic [3:0] ROW_J1 = 4'h0;
	localparam logic [3:0] ROW_B3 = 4'h1;
	localparam logic [3:0] ROW_G1 = 4'h3;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] IDLE_BYTE = 8'h00;
	localparam logic [4:0] G1_LOW_BITS = 5'h00;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;

	typedef enum logic [2:0] {
		SLOT_TOH, SLOT_H1, SLOT_H2, SLOT_H3, SLOT_POH, SLOT_PAY
	} spa_slot_kind_t;

	typedef struct packed {
		logic valid;
		spa_slot_kind_t kind;
		logic [3:0] row;
		logic [7:0] toh;
	} spa_slot_t;

	typedef struct packed {
		logic plm;
		logic uneq;
		logic lop;
		logic ais;
		logic tim;
		logic lcd;
	} spa_defect_t;
endpackage

// >>> rtl/spa_path_insert.sv
`timescale 1ns/100ps
`default_nettype none

module spa_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clock, // Byte clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic wr_valid, // Write side offers a word.
	input wire logic [WIDTH-1:0] wr_data, // Write word.
	output logic wr_ready, // Room for a word.
	output logic rd_valid, // A word is available.
	output logic [WIDTH-1:0] rd_data, // Oldest word.
	input wire logic rd_ready // Read side takes the word.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic full_q, full_d;
	logic push, pop;
	always_comb begin
		push = wr_valid && !full_q;
		pop = rd_ready && (cnt_q != '0);
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		full_d = (cnt_d == (AW+1)'(DEPTH));
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			full_q <= full_d;
		end
	end
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wp_q] <= wr_data;
		end
	end
	assign wr_ready = !full_q;
	assign rd_valid = (cnt_q != '0);
	assign rd_data = mem_q[rp_q];
endmodule // spa_fifo

// How it works
// [R1] Even BIP-8 of envelope goes in next B3.
// [R2] Far end checks prior envelope with B3.
// [R3] Computed B3 XORed with error mask.
// [R4] Mask resets zero; keep zero normally.
// [R5] AIS force makes whole envelope all ones.
// [R6] AIS force also sets H1-H3 all ones.
// [R7] AIS force discards incoming cell data.
// [R8] RDI from auto, software or external input.
// [R9] Six receive defects can raise RDI.
// [R10] Select 00 derives G1 bits 7:5 automatically.
// [R11] Mismatch code held in byte 2 bits 3:1.
// [R12] Byte 2 bit 0 enables mismatch reaction.
// [R13] Auto code lasts while defect stays declared.
// [R14] G1 is path status byte with RDI.
// [R15] Fixed priority: AIS, LOP first, PLM last.
// [R16] Settings change only at envelope boundary.
module spa_path_insert (
	input wire logic clock, // 20 MHz byte clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [15:0] reg_addr, // Register address.
	input wire logic [7:0] reg_wdata, // Register write data.
	input wire logic reg_wr, // Register write strobe.
	input wire logic reg_rd, // Register read strobe.
	output logic [7:0] reg_rdata, // Read data, valid one cycle later.
	input wire spa_pkg::spa_slot_t slot, // Byte slot from overhead side.
	input wire logic [7:0] external_path_overhead_input, // External POH.
	input wire spa_pkg::spa_defect_t defects, // Receive defect levels.
	input wire logic in_valid, // Cell or packet byte offered.
	input wire logic [7:0] in_data, // Cell or packet byte.
	output logic in_ready, // Buffer has room.
	output logic out_valid, // Outgoing byte valid.
	output logic [7:0] out_byte // Outgoing byte.
);
	logic [7:0] ctrl_q, ctrl_d, mask_q, mask_d, rdi0_q, rdi0_d;
	logic [7:0] rdi1_q, rdi1_d, rdi2_q, rdi2_d, swr_q, swr_d, rdata_d;
	logic ais_s_q, ais_s_d;
	logic [7:0] mask_s_q, mask_s_d, r0_s_q, r0_s_d, r1_s_q, r1_s_d;
	logic [7:0] r2_s_q, r2_s_d, sw_s_q, sw_s_d;
	logic [1:0] sel_s_q, sel_s_d;
	logic [7:0] bip_q, bip_d, b3_q, b3_d, tx, out_d;
	logic ov_d;
	logic boundary, spe, ais_eff, f_valid, f_pop, poh, b3_slot, g1_slot;
	logic [7:0] f_data;
	logic [2:0] auto_code, g1_code;
	spa_fifo #(.WIDTH(spa_pkg::FIFO_W), .DEPTH(spa_pkg::FIFO_D)) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.wr_valid(in_valid),
		.wr_data(in_data),
		.wr_ready(in_ready),
		.rd_valid(f_valid),
		.rd_data(f_data),
		.rd_ready(f_pop)
	);
	// Register file: live values written by software.
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		rdi0_d = rdi0_q;
		rdi1_d = rdi1_q;
		rdi2_d = rdi2_q;
		swr_d = swr_q;
		rdata_d = 8'h00;
		if (reg_wr) begin
			unique case (reg_addr)
				spa_pkg::OFS_CTRL0: ctrl_d = reg_wdata & spa_pkg::CTRL0_WMASK;
				spa_pkg::OFS_MASK: mask_d = reg_wdata;
				spa_pkg::OFS_RDI0: rdi0_d = reg_wdata;
				spa_pkg::OFS_RDI1: rdi1_d = reg_wdata;
				spa_pkg::OFS_RDI2: rdi2_d = reg_wdata;
				spa_pkg::OFS_SW_RDI: swr_d = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				spa_pkg::OFS_CTRL0: rdata_d = ctrl_q;
				spa_pkg::OFS_MASK: rdata_d = mask_q;
				spa_pkg::OFS_RDI0: rdata_d = rdi0_q;
				spa_pkg::OFS_RDI1: rdata_d = rdi1_q;
				spa_pkg::OFS_RDI2: rdata_d = rdi2_q;
				spa_pkg::OFS_SW_RDI: rdata_d = swr_q;
				spa_pkg::OFS_STATUS: rdata_d = {3'h0, !f_valid, auto_code, ais_s_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= spa_pkg::RST_CTRL0;
			mask_q <= spa_pkg::RST_MASK; // [R4]
			rdi0_q <= spa_pkg::RST_RDI;
			rdi1_q <= spa_pkg::RST_RDI;
			rdi2_q <= spa_pkg::RST_RDI;
			swr_q <= spa_pkg::RST_RDI;
			reg_rdata <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			rdi0_q <= rdi0_d;
			rdi1_q <= rdi1_d;
			rdi2_q <= rdi2_d;
			swr_q <= swr_d;
			reg_rdata <= rdata_d;
		end
	end
	// Shadow copies taken at J1 so one envelope never mixes settings.
	always_comb begin
		boundary = slot.valid && slot.kind == spa_pkg::SLOT_POH &&
			slot.row == spa_pkg::ROW_J1;
		spe = slot.valid && (slot.kind == spa_pkg::SLOT_POH ||
			slot.kind == spa_pkg::SLOT_PAY);
		ais_s_d = boundary ? ctrl_q[spa_pkg::CTRL_AIS_BIT] : ais_s_q; // [R16]
		mask_s_d = boundary ? mask_q : mask_s_q; // [R16]
		sel_s_d = boundary ? ctrl_q[spa_pkg::CTRL_RDI_SEL_LO +: 2] : sel_s_q;
		r0_s_d = boundary ? rdi0_q : r0_s_q;
		r1_s_d = boundary ? rdi1_q : r1_s_q;
		r2_s_d = boundary ? rdi2_q : r2_s_q;
		sw_s_d = boundary ? swr_q : sw_s_q;
		ais_eff = boundary ? ctrl_q[spa_pkg::CTRL_AIS_BIT] : ais_s_q;
		poh = slot.valid && slot.kind == spa_pkg::SLOT_POH;
		b3_slot = poh && slot.row == spa_pkg::ROW_B3;
		g1_slot = poh && slot.row == spa_pkg::ROW_G1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ais_s_q <= 1'b0;
			mask_s_q <= spa_pkg::RST_MASK;
			sel_s_q <= spa_pkg::RDI_SEL_AUTO;
			r0_s_q <= spa_pkg::RST_RDI;
			r1_s_q <= spa_pkg::RST_RDI;
			r2_s_q <= spa_pkg::RST_RDI;
			sw_s_q <= spa_pkg::RST_RDI;
		end else begin
			ais_s_q <= ais_s_d;
			mask_s_q <= mask_s_d;
			sel_s_q <= sel_s_d;
			r0_s_q <= r0_s_d;
			r1_s_q <= r1_s_d;
			r2_s_q <= r2_s_d;
			sw_s_q <= sw_s_d;
		end
	end
	// Remote defect code selection with fixed priority.
	always_comb begin
		auto_code = 3'h0; // [R13]
		if (defects.plm && r2_s_q[spa_pkg::EN_LO_BIT]) begin // [R12]
			auto_code = r2_s_q[spa_pkg::CODE_LO_POS +: 3]; // [R11]
		end
		if (defects.lcd && r2_s_q[spa_pkg::EN_HI_BIT]) begin // [R9]
			auto_code = r2_s_q[spa_pkg::CODE_HI_POS +: 3];
		end
		if (defects.uneq && r1_s_q[spa_pkg::EN_LO_BIT]) begin // [R9]
			auto_code = r1_s_q[spa_pkg::CODE_LO_POS +: 3];
		end
		if (defects.tim && r1_s_q[spa_pkg::EN_HI_BIT]) begin // [R9]
			auto_code = r1_s_q[spa_pkg::CODE_HI_POS +: 3];
		end
		if (defects.lop && r0_s_q[spa_pkg::EN_HI_BIT]) begin // [R15]
			auto_code = r0_s_q[spa_pkg::CODE_HI_POS +: 3];
		end
		if (defects.ais && r0_s_q[spa_pkg::EN_LO_BIT]) begin // [R15]
			auto_code = r0_s_q[spa_pkg::CODE_LO_POS +: 3];
		end
		unique case (sel_s_q) // [R8]
			spa_pkg::RDI_SEL_AUTO: g1_code = auto_code; // [R10]
			spa_pkg::RDI_SEL_SW: g1_code = sw_s_q[2:0];
			default: g1_code = external_path_overhead_input[7:5];
		endcase
	end
	// Outgoing byte, FIFO drain and path parity.
	always_comb begin
		f_pop = f_valid && (ais_eff || // [R7]
			(slot.valid && slot.kind == spa_pkg::SLOT_PAY));
		tx = slot.toh;
		unique case (slot.kind)
			default: tx = slot.toh;
			spa_pkg::SLOT_H1, spa_pkg::SLOT_H2, spa_pkg::SLOT_H3:
				tx = ais_eff ? spa_pkg::ALL_ONES : slot.toh; // [R6]
			spa_pkg::SLOT_POH: begin
				if (slot.row == spa_pkg::ROW_B3) begin
					tx = b3_q ^ mask_s_q; // [R3]
				end else if (slot.row == spa_pkg::ROW_G1) begin
					tx = {g1_code, spa_pkg::G1_LOW_BITS}; // [R14]
				end else begin
					tx = external_path_overhead_input;
				end
			end
			spa_pkg::SLOT_PAY: tx = f_valid ? f_data : spa_pkg::IDLE_BYTE;
		endcase
		if (spe && ais_eff) begin
			tx = spa_pkg::ALL_ONES; // [R5]
		end
		b3_d = boundary ? bip_q : b3_q; // [R1]
		bip_d = boundary ? tx : (spe ? bip_q ^ tx : bip_q); // [R1]
		ov_d = slot.valid;
		out_d = slot.valid ? tx : out_byte;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bip_q <= 8'h00;
			b3_q <= 8'h00;
			out_valid <= 1'b0;
			out_byte <= 8'h00;
		end else begin
			bip_q <= bip_d;
			b3_q <= b3_d;
			out_valid <= ov_d;
			out_byte <= out_d;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_b3_mask_xor: assert property (b3_slot && !ais_s_q |=> // [R3]
		out_byte == ($past(b3_q) ^ $past(mask_s_q)))
		else $error("B3 not masked parity");
	a_b3_from_bip: assert property (boundary |=> b3_q == $past(bip_q)) // [R1]
		else $error("B3 not previous parity");
	a_ais_spe_ones: assert property (spe && ais_eff |=> // [R5]
		out_byte == spa_pkg::ALL_ONES) else $error("AIS payload not ones");
	a_ais_ptr_ones: assert property (ais_eff && slot.valid && // [R6]
		slot.kind inside {[spa_pkg::SLOT_H1:spa_pkg::SLOT_H3]} |=>
		out_byte == spa_pkg::ALL_ONES) else $error("AIS pointer not ones");
	a_ais_drains_data: assert property (ais_eff && f_valid && // [R7]
		!in_valid |=> u_fifo.cnt_q == $past(u_fifo.cnt_q) - 1'b1)
		else $error("Data kept during AIS");
	a_plm_code_sent: assert property (g1_slot && !ais_s_q && // [R11]
		sel_s_q == spa_pkg::RDI_SEL_AUTO && r2_s_q[0] && defects == 6'h20 |=>
		out_byte[7:5] == $past(r2_s_q[3:1])) else $error("PLM code not sent");
	a_auto_reverts: assert property (g1_slot && !ais_s_q && // [R13]
		sel_s_q == spa_pkg::RDI_SEL_AUTO && defects == 6'h00 |=>
		out_byte[7:5] == 3'h0) else $error("Auto code stuck");
	a_ais_over_plm: assert property (defects.ais && r0_s_q[0] && // [R15]
		sel_s_q == spa_pkg::RDI_SEL_AUTO |-> g1_code == r0_s_q[3:1])
		else $error("AIS defect lost priority");
	a_settings_hold: assert property (!boundary |=> // [R16]
		$stable(ais_s_q) && $stable(mask_s_q) && $stable(sel_s_q))
		else $error("Setting changed mid envelope");
	c_ais_sent: cover property (ais_s_q && spe);
	c_plm_reported: cover property (defects.plm && r2_s_q[0] && g1_slot);
	c_b3_corrupted: cover property (mask_s_q != 8'h00 && b3_slot);
	c_fifo_full: cover property (!in_ready);
endmodule // spa_path_insert

`default_nettype wire

// >>> test/spa_toh_model.sv
`timescale 1ns/100ps
`default_nettype none
module spa_toh_model #(
	parameter int PAY = 2
) (
	input wire logic clock, // Byte clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic go, // Start one envelope.
	output spa_pkg::spa_slot_t slot, // Slot to block.
	output logic busy, // Envelope running.
	input wire logic out_valid, // Byte from block.
	input wire logic [7:0] out_byte, // Byte value.
	output logic [7:0] b3_got, // Last B3.
	output logic [7:0] b3_exp, // Prior parity.
	output logic [7:0] g1_got, // Last G1.
	output logic [7:0] ones_and // Pointer, J1, payload AND.
);
	localparam int LAST = 3 + 9 * (PAY + 1) - 1;
	int step;
	int s;
	logic [7:0] acc;
	spa_pkg::spa_slot_t prev;
	logic [7:0] pay_q[$];
	always_comb begin
		s = step - 3;
		slot.valid = busy;
		slot.toh = 8'h3c;
		slot.row = 4'h0;
		slot.kind = spa_pkg::SLOT_PAY;
		if (step < 3) begin
			slot.kind = spa_pkg::spa_slot_kind_t'(step + 1);
		end else if (s % (PAY + 1) == 0) begin
			slot.kind = spa_pkg::SLOT_POH;
		end
		if (step >= 3) begin
			slot.row = 4'(s / (PAY + 1));
		end
	end
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			step <= 0;
			acc <= 8'h00;
			b3_exp <= 8'h00;
			prev <= '0;
		end else begin
			prev <= slot;
			if (go && !busy) begin
				busy <= 1'b1;
				step <= 0;
				ones_and <= 8'hff;
				pay_q.delete();
			end else if (busy) begin
				step <= step + 1;
				busy <= (step != LAST);
			end
			if (out_valid) begin
				if (prev.kind == spa_pkg::SLOT_POH && prev.row == 4'h0) begin
					b3_exp <= acc;
					acc <= out_byte;
				end else if (prev.kind >= spa_pkg::SLOT_POH) begin
					acc <= acc ^ out_byte;
				end
				if (prev.kind == spa_pkg::SLOT_POH && prev.row == 4'h1) begin
					b3_got <= out_byte;
				end
				if (prev.kind == spa_pkg::SLOT_POH && prev.row == 4'h3) begin
					g1_got <= out_byte;
				end
				if (prev.kind != spa_pkg::SLOT_POH || prev.row == 4'h0) begin
					ones_and <= ones_and & out_byte;
				end
				if (prev.kind == spa_pkg::SLOT_PAY) begin
					pay_q.push_back(out_byte);
				end
			end
		end
	end
endmodule // spa_toh_model
`default_nettype wire

// >>> test/spa_path_insert_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spa_path_insert_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic in_valid = 1'b0;
	logic go = 1'b0;
	logic [7:0] in_data = 8'h00;
	logic [7:0] ext = 8'h00;
	spa_pkg::spa_defect_t defects = '0;
	spa_pkg::spa_slot_t slot;
	logic in_ready, out_valid, busy;
	logic [7:0] reg_rdata, out_byte, b3_got, b3_exp, g1_got, ones_and;
	logic [2:0] codes [6] = '{3'h7, 3'h2, 3'h3, 3'h6, 3'h1, 3'h5};
	int err_count = 0;
	int total_checks = 0;
	spa_path_insert spa_path_insert_inst (.clock(clock), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot(slot),
		.external_path_overhead_input(ext), .defects(defects),
		.in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
		.out_valid(out_valid), .out_byte(out_byte));
	spa_toh_model spa_toh_model_inst (.clock(clock), .rst_n(rst_n), .go(go),
		.slot(slot), .busy(busy), .out_valid(out_valid), .out_byte(out_byte),
		.b3_got(b3_got), .b3_exp(b3_exp), .g1_got(g1_got),
		.ones_and(ones_and));
	initial begin
		forever #25 clock = ~clock;
	end
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask
	task automatic env(input logic c, input logic [7:0] m);
		@(negedge clock);
		go = 1'b1;
		@(negedge clock);
		go = 1'b0;
		for (int i = 0; i < 60 && busy; i++) begin
			@(negedge clock);
		end
		repeat (2) @(negedge clock);
		if (c) begin
			chk(b3_got, b3_exp ^ m);
		end
	endtask
	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clock);
			in_valid = 1'b1;
			in_data = 8'h10 + 8'(i);
		end
	endtask
	initial begin
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		rd(spa_pkg::OFS_CTRL0, spa_pkg::RST_CTRL0);
		rd(spa_pkg::OFS_MASK, 8'h00);
		rd(spa_pkg::OFS_RDI2, spa_pkg::RST_RDI);
		rd(spa_pkg::OFS_STATUS, 8'h10);
		wr(16'h1234, 8'h77);
		rd(16'h1234, 8'h00);
		wr(spa_pkg::OFS_CTRL0, 8'hff);
		rd(spa_pkg::OFS_CTRL0, 8'hfd);
		wr(spa_pkg::OFS_CTRL0, 8'h00);
		push(17);
		chk({7'h00, in_ready}, 8'h00);
		@(negedge clock);
		in_valid = 1'b0;
		env(1'b1, 8'h00);
		for (int i = 0; i < 18; i++) begin
			chk(spa_toh_model_inst.pay_q[i], i < 16 ? 8'h10 + 8'(i) : 8'h00);
		end
		env(1'b1, 8'h00);
		wr(spa_pkg::OFS_MASK, 8'h5a);
		rd(spa_pkg::OFS_MASK, 8'h5a);
		env(1'b1, 8'h5a);
		wr(spa_pkg::OFS_MASK, 8'h00);
		wr(spa_pkg::OFS_RDI0, 8'hd7);
		wr(spa_pkg::OFS_RDI1, 8'h53);
		wr(spa_pkg::OFS_RDI2, 8'hfb);
		rd(spa_pkg::OFS_RDI2, 8'hfb);
		for (int i = 0; i < 6; i++) begin
			defects = spa_pkg::spa_defect_t'(6'h01 << i);
			env(1'b0, 8'h00);
			chk(g1_got, {codes[i], spa_pkg::G1_LOW_BITS});
		end
		defects = 6'h24;
		env(1'b0, 8'h00);
		chk(g1_got, 8'h60);
		defects = 6'h0a;
		env(1'b0, 8'h00);
		chk(g1_got, 8'hc0);
		rd(spa_pkg::OFS_STATUS, 8'h1c);
		defects = 6'h00;
		env(1'b0, 8'h00);
		chk(g1_got, 8'h00);
		wr(spa_pkg::OFS_RDI2, 8'hfa);
		defects = 6'h20;
		env(1'b0, 8'h00);
		chk(g1_got, 8'h00);
		defects = 6'h00;
		wr(spa_pkg::OFS_CTRL0, 8'h08);
		wr(spa_pkg::OFS_SW_RDI, 8'h04);
		env(1'b0, 8'h00);
		chk(g1_got, 8'h80);
		wr(spa_pkg::OFS_CTRL0, 8'h10);
		ext = 8'ha0;
		env(1'b0, 8'h00);
		chk(g1_got, 8'ha0);
		wr(spa_pkg::OFS_CTRL0, 8'h01);
		push(4);
		@(negedge clock);
		in_valid = 1'b0;
		env(1'b0, 8'h00);
		env(1'b0, 8'h00);
		chk(ones_and, 8'hff);
		chk({7'h00, in_ready}, 8'h01);
		rd(spa_pkg::OFS_STATUS, 8'h11);
		wr(spa_pkg::OFS_CTRL0, 8'h00);
		env(1'b0, 8'h00);
		for (int i = 0; i < 18; i++) begin
			chk(spa_toh_model_inst.pay_q[i], 8'h00);
		end
		final_report();
	end
	initial begin
		repeat (5000) @(posedge clock);
		err_count++;
		final_report();
	end
endmodule // spa_path_insert_tb
`default_nettype wire
